//--- rtl/bifs_pkg.sv
// binary input function select: constants, register map, types
// assumes a 100 MHz processing clock and an APB register bus
package bifs_pkg;

  localparam int          SEL_N   = 6;
  localparam int          DW      = 16;
  localparam int          SW      = 19;
  localparam int          FN_W    = 15;
  localparam int          AW      = 8;

  // ---------------------------------------------------------------
  // function codes of the select inputs
  // ---------------------------------------------------------------
  localparam logic [5:0]  FC_BASE = 6'h15;
  localparam logic [5:0]  FC_LAST = 6'h23;

  // bit of each function in the active / assigned vectors
  localparam int          FB_SPD  = 0;
  localparam int          FB_TRQ  = 1;
  localparam int          FB_CUR  = 2;
  localparam int          FB_RED  = 3;
  localparam int          FB_AUTO = 4;
  localparam int          FB_UP   = 5;
  localparam int          FB_DN   = 6;
  localparam int          FB_DSW  = 7;
  localparam int          FB_PBP  = 8;
  localparam int          FB_PBN  = 9;
  localparam int          FB_RS2  = 10;
  localparam int          FB_RS3  = 11;
  localparam int          FB_PS2  = 12;
  localparam int          FB_PS3  = 13;
  localparam int          FB_PS4  = 14;

  // control word may not drive the pushbutton direction functions
  localparam logic [14:0] CW_MASK = 15'h7CFF;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_CW     = 8'h04;
  localparam logic [7:0]  ADDR_STAT   = 8'h08;
  localparam logic [7:0]  ADDR_FUNC0  = 8'h10;
  localparam logic [7:0]  ADDR_DSP0   = 8'h30;
  localparam logic [7:0]  ADDR_CWSPD  = 8'h50;
  localparam logic [7:0]  ADDR_CWTRQ  = 8'h54;
  localparam logic [7:0]  ADDR_CWCUR  = 8'h58;
  localparam logic [7:0]  ADDR_LIMPOS = 8'h60;
  localparam logic [7:0]  ADDR_LIMNEG = 8'h64;
  localparam logic [7:0]  ADDR_REDPOS = 8'h68;
  localparam logic [7:0]  ADDR_REDNEG = 8'h6C;
  localparam logic [7:0]  ADDR_STEP   = 8'h04;

  localparam int          CTRL_RUN = 0;
  localparam int          CTRL_OPT = 1;
  localparam int          CTRL_ACK = 2;

  localparam logic [15:0] LIMPOS_RST = 16'h7FFF;
  localparam logic [15:0] LIMNEG_RST = 16'h8001;
  localparam logic [15:0] REDPOS_RST = 16'h3FFF;
  localparam logic [15:0] REDNEG_RST = 16'hC001;

  localparam logic [1:0]  RSET_ONE   = 2'h1;
  localparam logic [1:0]  RSET_TWO   = 2'h2;
  localparam logic [1:0]  RSET_THREE = 2'h3;

  localparam logic [1:0]  PSET_ONE   = 2'h0;
  localparam logic [1:0]  PSET_TWO   = 2'h1;
  localparam logic [1:0]  PSET_THREE = 2'h2;
  localparam logic [1:0]  PSET_FOUR  = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_KHZ        = 100000;
  localparam int          FLT_DELAY_MS   = 500;
  localparam int          FLT_DELAY_CYC  = FLT_DELAY_MS * CLK_KHZ;
  localparam int          PSET_LATE_MS   = 25;
  localparam int          PSET_LATE_CYC  = PSET_LATE_MS * CLK_KHZ;
  localparam int          CNT_W          = 26;

  typedef enum logic [1:0] {
    FLT_CLEAR   = 2'b01,
    FLT_TRIPPED = 2'b10
  } bifs_flt_e;

endpackage

//--- rtl/bifs_top.sv
// binary input function select: decodes six select inputs and the
// free control word into setpoint, motor pot, ramp and parameter set
// controls; assumes synchronous inputs and an APB master on pclk
`timescale 1ns/10ps
module bifs_top
  import bifs_pkg::*;
#(
  parameter int unsigned FAULT_DELAY_CYC = FLT_DELAY_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [AW-1:0]        paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [SEL_N-1:0]     sel_in,
  input  wire logic signed [DW-1:0] ramp_gen_out,
  input  wire logic signed [DW-1:0] speed_ctrl_out,
  input  wire logic signed [DW-1:0] current_sp,
  output logic signed [SW-1:0]      speed_sp_out,
  output logic signed [SW-1:0]      torque_sp_out,
  output logic signed [SW-1:0]      current_sp_out,
  output logic      [DW-1:0]        ramp_in_pos_lim,
  output logic      [DW-1:0]        ramp_in_neg_lim,
  output logic                      motpot_auto_sel,
  output logic                      motpot_raise,
  output logic                      motpot_lower,
  output logic                      motpot_neg,
  output logic      [1:0]           ramp_set,
  output logic                      ramp_integ_override,
  output logic      [1:0]           param_set,
  output logic                      selection_conflict_fault
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [FN_W-1:0] code_bit(input logic [5:0] c);
    logic [5:0] d;
    d = c - FC_BASE;
    code_bit = '0;
    if (c >= FC_BASE && c <= FC_LAST) begin
      code_bit[d[3:0]] = 1'b1;
    end
  endfunction

  function automatic logic signed [SW-1:0] sext(input logic [DW-1:0] v);
    sext = {{(SW-DW){v[DW-1]}}, v};
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [5:0]       func_reg [SEL_N];
  logic [DW-1:0]    dsp_reg  [SEL_N];
  logic             run_en_reg;
  logic             opt_run_reg;
  logic             ack_pulse;
  logic [FN_W-1:0]  free_control_word;
  logic [DW-1:0]    cw_supp_speed_value;
  logic [DW-1:0]    cw_supp_torque_value;
  logic [DW-1:0]    cw_supp_current_value;
  logic [DW-1:0]    lim_pos_reg;
  logic [DW-1:0]    lim_neg_reg;
  logic [DW-1:0]    red_pos_reg;
  logic [DW-1:0]    red_neg_reg;
  logic [31:0]      prdata_next;
  logic             rd_ok;
  logic             wr_acc;

  assign wr_acc = psel && penable && pwrite;

  genvar gi;
  generate
    for (gi = 0; gi < SEL_N; gi++) begin : g_regs
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          func_reg[gi] <= '0;
          dsp_reg[gi]  <= '0;
        end else if (wr_acc) begin
          if (paddr == ADDR_FUNC0 + AW'(gi) * ADDR_STEP) begin
            func_reg[gi] <= pwdata[5:0];
          end
          if (paddr == ADDR_DSP0 + AW'(gi) * ADDR_STEP) begin
            dsp_reg[gi] <= pwdata[DW-1:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_reg            <= 1'b0;
      opt_run_reg           <= 1'b0;
      ack_pulse             <= 1'b0;
      free_control_word     <= '0;
      cw_supp_speed_value   <= '0;
      cw_supp_torque_value  <= '0;
      cw_supp_current_value <= '0;
      lim_pos_reg           <= LIMPOS_RST;
      lim_neg_reg           <= LIMNEG_RST;
      red_pos_reg           <= REDPOS_RST;
      red_neg_reg           <= REDNEG_RST;
    end else begin
      ack_pulse <= wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_ACK];
      if (wr_acc) begin
        case (paddr)
          ADDR_CTRL: begin
            run_en_reg  <= pwdata[CTRL_RUN];
            opt_run_reg <= pwdata[CTRL_OPT];
          end
          ADDR_CW:     free_control_word     <= pwdata[FN_W-1:0];
          ADDR_CWSPD:  cw_supp_speed_value   <= pwdata[DW-1:0];
          ADDR_CWTRQ:  cw_supp_torque_value  <= pwdata[DW-1:0];
          ADDR_CWCUR:  cw_supp_current_value <= pwdata[DW-1:0];
          ADDR_LIMPOS: lim_pos_reg           <= pwdata[DW-1:0];
          ADDR_LIMNEG: lim_neg_reg           <= pwdata[DW-1:0];
          ADDR_REDPOS: red_pos_reg           <= pwdata[DW-1:0];
          ADDR_REDNEG: red_neg_reg           <= pwdata[DW-1:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux, zero wait state
  // ---------------------------------------------------------------
  always_comb begin
    prdata_next = '0;
    rd_ok       = 1'b1;
    case (paddr)
      ADDR_CTRL:   prdata_next = 32'({opt_run_reg, run_en_reg});
      ADDR_CW:     prdata_next = 32'(free_control_word);
      ADDR_STAT:   prdata_next = 32'({motpot_neg, motpot_auto_sel, ramp_set,
                                      param_set, selection_conflict_fault});
      ADDR_CWSPD:  prdata_next = 32'(cw_supp_speed_value);
      ADDR_CWTRQ:  prdata_next = 32'(cw_supp_torque_value);
      ADDR_CWCUR:  prdata_next = 32'(cw_supp_current_value);
      ADDR_LIMPOS: prdata_next = 32'(lim_pos_reg);
      ADDR_LIMNEG: prdata_next = 32'(lim_neg_reg);
      ADDR_REDPOS: prdata_next = 32'(red_pos_reg);
      ADDR_REDNEG: prdata_next = 32'(red_neg_reg);
      default:     rd_ok       = 1'b0;
    endcase
    for (int i = 0; i < SEL_N; i++) begin
      if (paddr == ADDR_FUNC0 + AW'(i) * ADDR_STEP) begin
        prdata_next = 32'(func_reg[i]);
        rd_ok       = 1'b1;
      end
      if (paddr == ADDR_DSP0 + AW'(i) * ADDR_STEP) begin
        prdata_next = 32'(dsp_reg[i]);
        rd_ok       = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      if (psel && !penable) begin
        prdata  <= pwrite ? '0 : prdata_next;
        pslverr <= !rd_ok;
      end
    end
  end

  // ---------------------------------------------------------------
  // input sampling and function decode
  // ---------------------------------------------------------------
  logic [SEL_N-1:0] sel_q;
  logic [FN_W-1:0]  term_hit [SEL_N];
  logic [FN_W-1:0]  asg_hit  [SEL_N];
  logic [FN_W-1:0]  act;
  logic [FN_W-1:0]  asg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= '0;
    end else begin
      sel_q <= sel_in;
    end
  end

  generate
    for (gi = 0; gi < SEL_N; gi++) begin : g_dec
      assign asg_hit[gi]  = code_bit(func_reg[gi]);
      assign term_hit[gi] = sel_q[gi] ? asg_hit[gi] : '0;
    end
  endgenerate

  always_comb begin
    act = free_control_word & CW_MASK;
    asg = '0;
    for (int i = 0; i < SEL_N; i++) begin
      act = act | term_hit[i];
      asg = asg | asg_hit[i];
    end
  end

  // ---------------------------------------------------------------
  // supplementary setpoints
  // ---------------------------------------------------------------
  logic signed [SW-1:0] sum_spd;
  logic signed [SW-1:0] sum_trq;
  logic signed [SW-1:0] sum_cur;

  always_comb begin
    sum_spd = free_control_word[FB_SPD] ? sext(cw_supp_speed_value) : '0;
    sum_trq = free_control_word[FB_TRQ] ? sext(cw_supp_torque_value) : '0;
    sum_cur = free_control_word[FB_CUR] ? sext(cw_supp_current_value) : '0;
    for (int i = 0; i < SEL_N; i++) begin
      if (term_hit[i][FB_SPD]) begin
        sum_spd = sum_spd + sext(dsp_reg[i]);
      end
      if (term_hit[i][FB_TRQ]) begin
        sum_trq = sum_trq + sext(dsp_reg[i]);
      end
      if (term_hit[i][FB_CUR]) begin
        sum_cur = sum_cur + sext(dsp_reg[i]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_sp_out   <= '0;
      torque_sp_out  <= '0;
      current_sp_out <= '0;
    end else if (run_en_reg) begin
      speed_sp_out   <= sext(ramp_gen_out) + sum_spd;
      torque_sp_out  <= sext(speed_ctrl_out) + sum_trq;
      current_sp_out <= sext(current_sp) + sum_cur;
    end else begin
      speed_sp_out   <= sext(ramp_gen_out);
      torque_sp_out  <= sext(speed_ctrl_out);
      current_sp_out <= sext(current_sp);
    end
  end

  // ---------------------------------------------------------------
  // setpoint reduction and ramp set
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_in_pos_lim <= LIMPOS_RST;
      ramp_in_neg_lim <= LIMNEG_RST;
    end else begin
      ramp_in_pos_lim <= act[FB_RED] ? red_pos_reg : lim_pos_reg;
      ramp_in_neg_lim <= act[FB_RED] ? red_neg_reg : lim_neg_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_set            <= RSET_ONE;
      ramp_integ_override <= 1'b0;
    end else begin
      ramp_integ_override <= act[FB_RS2] || act[FB_RS3];
      if (act[FB_RS3]) begin
        ramp_set <= RSET_THREE;
      end else if (act[FB_RS2]) begin
        ramp_set <= RSET_TWO;
      end else begin
        ramp_set <= RSET_ONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // motorized potentiometer
  // ---------------------------------------------------------------
  logic btn_asg;
  assign btn_asg = asg[FB_PBP] || asg[FB_PBN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motpot_auto_sel <= 1'b0;
      motpot_raise    <= 1'b0;
      motpot_lower    <= 1'b0;
      motpot_neg      <= 1'b0;
    end else begin
      motpot_auto_sel <= act[FB_AUTO];
      motpot_lower    <= act[FB_DN];
      motpot_raise    <= act[FB_UP] && !act[FB_DN];
      if (btn_asg) begin
        if (act[FB_PBN]) begin
          motpot_neg <= 1'b1;
        end else if (act[FB_PBP]) begin
          motpot_neg <= 1'b0;
        end
      end else begin
        motpot_neg <= act[FB_DSW];
      end
    end
  end

  // ---------------------------------------------------------------
  // parameter set selection
  // ---------------------------------------------------------------
  logic [2:0]       ps_vec;
  logic [2:0]       ps_ref;
  logic             ps_amb;
  logic             ps_dev;
  logic [CNT_W-1:0] amb_cnt;
  logic [CNT_W-1:0] opt_cnt;
  logic             amb_trip;
  logic             opt_trip;

  assign ps_vec   = {act[FB_PS4], act[FB_PS3], act[FB_PS2]};
  assign ps_amb   = ps_vec != '0 && (ps_vec & (ps_vec - 3'h1)) != '0;
  assign ps_dev   = opt_run_reg && ps_vec != ps_ref;
  assign amb_trip = ps_amb && amb_cnt == CNT_W'(FAULT_DELAY_CYC - 1);
  assign opt_trip = ps_dev && opt_cnt == CNT_W'(FAULT_DELAY_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param_set <= PSET_ONE;
    end else begin
      case (ps_vec)
        3'b000:  param_set <= PSET_ONE;
        3'b001:  param_set <= PSET_TWO;
        3'b010:  param_set <= PSET_THREE;
        3'b100:  param_set <= PSET_FOUR;
        default: param_set <= param_set;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amb_cnt <= '0;
    end else if (!ps_amb) begin
      amb_cnt <= '0;
    end else if (!amb_trip) begin
      amb_cnt <= amb_cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_ref  <= '0;
      opt_cnt <= '0;
    end else begin
      if (!opt_run_reg) begin
        ps_ref <= ps_vec;
      end
      if (!ps_dev) begin
        opt_cnt <= '0;
      end else if (!opt_trip) begin
        opt_cnt <= opt_cnt + CNT_W'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration fault latch
  // ---------------------------------------------------------------
  bifs_flt_e flt_reg;
  bifs_flt_e flt_next;
  logic      flt_set;

  assign flt_set = (act[FB_RS2] && act[FB_RS3]) || amb_trip || opt_trip;

  always_comb begin
    flt_next = flt_reg;
    case (flt_reg)
      FLT_CLEAR:   flt_next = flt_set ? FLT_TRIPPED : FLT_CLEAR;
      FLT_TRIPPED: flt_next = (ack_pulse && !flt_set) ? FLT_CLEAR : FLT_TRIPPED;
      default:     flt_next = FLT_CLEAR;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_reg                  <= FLT_CLEAR;
      selection_conflict_fault <= 1'b0;
    end else begin
      flt_reg                  <= flt_next;
      selection_conflict_fault <= flt_next == FLT_TRIPPED;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_supp_off;
    !run_en_reg |=> speed_sp_out == sext($past(ramp_gen_out));
  endproperty
  a_supp_off: assert property (p_supp_off) else $error("supplement while not run");

  property p_supp_sum;
    run_en_reg |=> torque_sp_out == $past(sext(speed_ctrl_out) + sum_trq);
  endproperty
  a_supp_sum: assert property (p_supp_sum) else $error("torque supplement sum");

  property p_lower_prio;
    act[FB_DN] |=> motpot_lower && !motpot_raise;
  endproperty
  a_lower_prio: assert property (p_lower_prio) else $error("lower must beat raise");

  property p_reduce;
    act[FB_RED] |=> ramp_in_pos_lim == $past(red_pos_reg)
                    && ramp_in_neg_lim == $past(red_neg_reg);
  endproperty
  a_reduce: assert property (p_reduce) else $error("reduced limits not used");

  property p_button_hold;
    btn_asg && !act[FB_PBP] && !act[FB_PBN] |=> $stable(motpot_neg);
  endproperty
  a_button_hold: assert property (p_button_hold) else $error("polarity not held");

  property p_ramp_conflict;
    act[FB_RS2] && act[FB_RS3] |=> selection_conflict_fault;
  endproperty
  a_ramp_conflict: assert property (p_ramp_conflict) else $error("ramp conflict no trip");

  property p_pset_one;
    ps_vec == '0 |=> param_set == PSET_ONE;
  endproperty
  a_pset_one: assert property (p_pset_one) else $error("set one not used");

  property p_pset_amb;
    ps_amb |=> param_set == $past(param_set);
  endproperty
  a_pset_amb: assert property (p_pset_amb) else $error("set changed while ambiguous");

  property p_amb_trip;
    amb_trip |=> selection_conflict_fault;
  endproperty
  a_amb_trip: assert property (p_amb_trip) else $error("ambiguity did not trip");

  property p_fault_latch;
    selection_conflict_fault && !ack_pulse |=> selection_conflict_fault;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault dropped without ack");

  c_fault:  cover property ($rose(selection_conflict_fault));
  c_pset:   cover property (param_set == PSET_ONE ##1 param_set == PSET_FOUR);
  c_supp:   cover property (run_en_reg && sum_spd != '0);
  c_motpot: cover property ($rose(motpot_neg) && btn_asg);

endmodule

//--- verification/bifs_term_model.sv
// select input terminals as seen by the block
// assumes requests from the bench, change held at least one cycle
`timescale 1ns/10ps
module bifs_term_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] req,
  output logic      [5:0] sel_in
);
  // ---------------------------------------------------------------
  // terminal levels
  // ---------------------------------------------------------------
  // levels change only on request, held steady otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_in <= 6'h00;
    end else begin
      sel_in <= req;
    end
  end
endmodule

//--- verification/tb_top.sv
// bench for the binary input function select block
// assumes APB zero wait answers and fault delay shortened to 20
`timescale 1ns/10ps
module tb_top
  import bifs_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [AW-1:0]     paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [5:0]        req, sel_in;
  logic signed [15:0] ramp, spd, cur;
  logic signed [18:0] so, to, co;
  logic [15:0]       lp, ln;
  logic              au, up, dn, ng, io, flt;
  logic [1:0]        rs, ps;
  int                num_errors, checks;
  logic [5:0]        fc [6] = '{6'h15, 6'h15, 6'h18, 6'h1B, 6'h1A, 6'h1F};

  bifs_term_model i_term (.pclk(pclk), .presetn(presetn), .req(req), .sel_in(sel_in));
  bifs_top #(.FAULT_DELAY_CYC(20)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sel_in(sel_in), .ramp_gen_out(ramp), .speed_ctrl_out(spd),
    .current_sp(cur), .speed_sp_out(so), .torque_sp_out(to), .current_sp_out(co),
    .ramp_in_pos_lim(lp), .ramp_in_neg_lim(ln), .motpot_auto_sel(au),
    .motpot_raise(up), .motpot_lower(dn), .motpot_neg(ng), .ramp_set(rs),
    .ramp_integ_override(io), .param_set(ps), .selection_conflict_fault(flt));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic drv(input logic [5:0] v);
    @(posedge pclk);
    req <= v;
    wt(4);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, tests
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #50000;
    num_errors++;
    complete_run;
  end
  initial begin
    presetn <= 1'b0;
    {psel, penable, pwrite, paddr, pwdata, req} <= '0;
    ramp <= 16'sh0100;
    spd <= 16'sh0200;
    cur <= 16'sh0300;
    wt(12);
    presetn <= 1'b1;
    wt(2);
    chk(32'(lp), 32'h7FFF);
    chk(32'(rs), 32'(RSET_ONE));
    apb(1'b0, 8'hFC, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, ADDR_REDPOS, 32'h0);
    chk(rd, 32'h3FFF);
    for (int i = 0; i < 6; i++) apb(1'b1, ADDR_FUNC0 + 8'(4 * i), 32'(fc[i]));
    apb(1'b1, ADDR_DSP0, 32'h10);
    apb(1'b1, ADDR_DSP0 + 8'h04, 32'h20);
    apb(1'b1, ADDR_CTRL, 32'h1);
    drv(6'h03);
    chk({13'h0, so}, 32'h130);
    drv(6'h04);
    chk(32'(lp), 32'(REDPOS_RST));
    chk(32'(ln), 32'(REDNEG_RST));
    drv(6'h18);
    chk(32'({dn, up}), 32'h2);
    drv(6'h10);
    chk(32'(up), 32'h1);
    drv(6'h03);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wt(3);
    chk({13'h0, so}, 32'h100);
    drv(6'h00);
    apb(1'b1, ADDR_CWSPD, 32'h5);
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_CW, 32'h1);
    wt(3);
    chk({13'h0, so}, 32'h105);
    apb(1'b1, ADDR_CW, 32'h0);
    apb(1'b1, ADDR_FUNC0 + 8'h10, 32'h20);
    drv(6'h20);
    chk(32'({io, rs}), 32'h6);
    drv(6'h30);
    chk(32'(flt), 32'h1);
    drv(6'h00);
    chk(32'(flt), 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h5);
    wt(3);
    chk(32'(flt), 32'h0);
    drv(6'h10);
    chk(32'({io, rs}), 32'h7);
    apb(1'b1, ADDR_FUNC0, 32'h21);
    apb(1'b1, ADDR_FUNC0 + 8'h04, 32'h22);
    drv(6'h01);
    chk(32'(ps), 32'(PSET_TWO));
    drv(6'h03);
    chk(32'({flt, ps}), 32'(PSET_TWO));
    wt(25);
    chk(32'(flt), 32'h1);
    drv(6'h02);
    apb(1'b1, ADDR_CTRL, 32'h5);
    wt(2);
    chk(32'({flt, ps}), 32'(PSET_THREE));
    apb(1'b1, ADDR_CTRL, 32'h3);
    drv(6'h01);
    chk(32'({flt, ps}), 32'(PSET_TWO));
    wt(25);
    chk(32'(flt), 32'h1);
    drv(6'h02);
    apb(1'b1, ADDR_CTRL, 32'h5);
    apb(1'b1, ADDR_FUNC0, 32'h16);
    apb(1'b1, ADDR_FUNC0 + 8'h04, 32'h17);
    apb(1'b1, ADDR_FUNC0 + 8'h08, 32'h19);
    apb(1'b1, ADDR_FUNC0 + 8'h0C, 32'h1C);
    drv(6'h0F);
    chk({13'h0, to}, 32'h210);
    chk({13'h0, co}, 32'h320);
    chk(32'({au, ng}), 32'h3);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd, 32'h68);
    apb(1'b1, ADDR_FUNC0 + 8'h10, 32'h1D);
    apb(1'b1, ADDR_FUNC0 + 8'h14, 32'h1E);
    drv(6'h10);
    chk(32'(ng), 32'h0);
    drv(6'h08);
    chk(32'(ng), 32'h0);
    drv(6'h20);
    chk(32'(ng), 32'h1);
    drv(6'h00);
    apb(1'b1, ADDR_CW, 32'h100);
    wt(3);
    chk(32'(ng), 32'h1);
    complete_run;
  end
endmodule
